// ===== rtl/srp_pkg.sv
// Shared constants and types for the sensor serial register port.
package srp_pkg;

    // ------------------------------------------------------------------
    // Bus addressing and byte layout
    // ------------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR_DFLT = 7'h5F;
    localparam logic [4:0] MCODE_PREFIX = 5'h01;
    localparam int BYTE_BITS = 8;
    localparam int DIR_BIT = 0;
    localparam int PTR_INC_BIT = 7;
    localparam logic [6:0] PTR_RST = 7'h00;
    localparam logic [7:0] TX_RST = 8'hFF;

    // ------------------------------------------------------------------
    // Timing: fast mode SCL phases against the core clock
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCL_LOW_MIN_NS = 1300;
    localparam int SCL_HIGH_MIN_NS = 600;
    localparam int SCL_LOW_MIN_CYC = (SCL_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCL_HIGH_MIN_CYC = (SCL_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EDGE_LAT_CYC = 3;

    // ------------------------------------------------------------------
    // Protocol states and byte kinds
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_RX = 3'b001,
        S_ACK = 3'b010,
        S_NACK = 3'b011,
        S_LOAD = 3'b100,
        S_TX = 3'b101,
        S_MACK = 3'b110,
        S_IGNORE = 3'b111
    } srp_state_t;

    typedef enum logic [1:0] {
        K_ADDR = 2'b00,
        K_PTR = 2'b01,
        K_DATA = 2'b10
    } srp_kind_t;

endpackage

// ===== rtl/srp_line_monitor.sv
// Pin synchroniser and START, STOP and SCL edge detector.
`timescale 1ns/100ps
module srp_line_monitor (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sel_i,
    output logic scl_s_o,
    output logic sda_s_o,
    output logic sel_s_o,
    output logic scl_rise_o,
    output logic scl_fall_o,
    output logic start_o,
    output logic stop_o
);

    // ------------------------------------------------------------------
    // Two-stage synchroniser plus one history stage
    // ------------------------------------------------------------------
    // Bit 0 is SCL, bit 1 is SDA, bit 2 is the interface select.
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic [2:0] prev_r;
    logic [2:0] meta_nxt;
    logic [2:0] sync_nxt;
    logic [2:0] prev_nxt;

    // The first stage feeds only the second; all decoding uses later stages.
    always_comb begin
        meta_nxt = {sel_i, sda_i, scl_i};
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    // Lines idle high, and an open select pin reads as I2C.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_r <= 3'h7;
            sync_r <= 3'h7;
            prev_r <= 3'h7;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Condition decoding
    // ------------------------------------------------------------------
    // START and STOP need SCL high in both samples around the SDA edge.
    assign scl_s_o = sync_r[0];
    assign sda_s_o = sync_r[1];
    assign sel_s_o = sync_r[2];
    assign scl_rise_o = sync_r[0] & ~prev_r[0];
    assign scl_fall_o = ~sync_r[0] & prev_r[0];
    assign start_o = sync_r[0] & prev_r[0] & prev_r[1] & ~sync_r[1];
    assign stop_o = sync_r[0] & prev_r[0] & ~prev_r[1] & sync_r[1];

endmodule

// ===== rtl/srp_rx_shifter.sv
// Receive shift register with bit counter, MSB first.
`timescale 1ns/100ps
module srp_rx_shifter #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic clear_i,
    input wire logic sample_i,
    input wire logic bit_i,
    output logic [W-1:0] byte_o,
    output logic full_o
);

    localparam int CW = $clog2(W + 1);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (W < 2) begin : g_bad_width
        $error("Shifter width must be at least two bits.");
    end

    logic [W-1:0] shift_r;
    logic [W-1:0] shift_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // Shift in at the low end so the first bit ends at the top.
    always_comb begin
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        if (clear_i) begin
            cnt_nxt = '0;
        end else if (sample_i && !full_o) begin
            shift_nxt = {shift_r[W-2:0], bit_i};
            cnt_nxt = CW'(cnt_r + 1'b1);
        end
    end

    // Register the shift state.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_r <= '0;
            cnt_r <= '0;
        end else begin
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign byte_o = shift_r;
    assign full_o = (cnt_r == CW'(W));

endmodule

// ===== rtl/srp_i2c_port.sv
// I2C target register port of the sensor, with pointer and auto-increment.
//
// Contract
// [RL1] Select high or open: I2C; low: SPI.
// [RL2] SDA fall, SCL high: START, bus busy.
// [RL3] First byte: seven address bits, direction.
// [RL4] Own address 1011111; BEh write, BFh read.
// [RL5] Receiver holds SDA low through acknowledge high.
// [RL6] Acknowledge every byte received once addressed.
// [RL7] Pointer byte: low seven address, top increment.
// [RL8] Top bit set advances address each byte.
// [RL9] Write: address, pointer, data bytes, STOP.
// [RL10] Read: pointer, repeated START, data, final NACK.
// [RL11] Bytes are eight bits, MSB first, unlimited.
// [RL12] Receiver may hold SCL low to wait.
// [RL13] Unaccepted address leaves SDA high.
// [RL14] SDA rise, SCL high: STOP ends transaction.
// [RL15] Works at standard and fast mode clocks.
// [RL16] Master code never acknowledged, not an address.
// [RL17] High-speed mode lasts until the STOP.
// [RL18] Mismatch: release SDA until next START.
`timescale 1ns/100ps
module srp_i2c_port #(
    parameter logic [6:0] TARGET_ADDR = srp_pkg::TARGET_ADDR_DFLT
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic if_sel_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic [6:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_ready_i,
    output logic busy_o,
    output logic hs_mode_o
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The edge detector must see each SCL phase well inside its minimum width.
    if (srp_pkg::EDGE_LAT_CYC >= srp_pkg::SCL_HIGH_MIN_CYC) begin : g_bad_timing // [RL15]
        $error("Core clock too slow for fast-mode SCL phases.");
    end
    if (TARGET_ADDR[6:2] == srp_pkg::MCODE_PREFIX) begin : g_bad_addr
        $error("Target address collides with the master code range.");
    end

    // ------------------------------------------------------------------
    // Line monitor and receive shifter
    // ------------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic sel_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic rx_clear;
    logic rx_sample;
    logic [7:0] rx_byte;
    logic rx_full;

    srp_line_monitor u_mon (
        .clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sel_i(if_sel_i),
        .scl_s_o(scl_s),
        .sda_s_o(sda_s),
        .sel_s_o(sel_s),
        .scl_rise_o(scl_rise),
        .scl_fall_o(scl_fall),
        .start_o(start_det),
        .stop_o(stop_det)
    );

    srp_rx_shifter #(
        .W(srp_pkg::BYTE_BITS)
    ) u_rx (
        .clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .clear_i(rx_clear),
        .sample_i(rx_sample),
        .bit_i(sda_s),
        .byte_o(rx_byte),
        .full_o(rx_full)
    );

    // ------------------------------------------------------------------
    // Protocol state
    // ------------------------------------------------------------------
    srp_pkg::srp_state_t state_r;
    srp_pkg::srp_state_t state_nxt;
    srp_pkg::srp_kind_t kind_r;
    srp_pkg::srp_kind_t kind_nxt;
    logic dir_r;
    logic dir_nxt;
    logic [6:0] ptr_r;
    logic [6:0] ptr_nxt;
    logic inc_r;
    logic inc_nxt;
    logic [7:0] tx_r;
    logic [7:0] tx_nxt;
    logic [2:0] txcnt_r;
    logic [2:0] txcnt_nxt;
    logic wait_r;
    logic wait_nxt;
    logic mack_r;
    logic mack_nxt;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic wr_r;
    logic wr_nxt;
    logic rd_r;
    logic rd_nxt;
    logic [7:0] wdata_r;
    logic [7:0] wdata_nxt;
    logic busy_r;
    logic busy_nxt;
    logic hs_r;
    logic hs_nxt;

    // Next-state logic: bits are taken on SCL rise and SDA moves only after SCL fall.
    always_comb begin
        state_nxt = state_r;
        kind_nxt = kind_r;
        dir_nxt = dir_r;
        ptr_nxt = ptr_r;
        inc_nxt = inc_r;
        tx_nxt = tx_r;
        txcnt_nxt = txcnt_r;
        wait_nxt = wait_r;
        mack_nxt = mack_r;
        wr_nxt = 1'b0;
        rd_nxt = 1'b0;
        wdata_nxt = wdata_r;
        busy_nxt = busy_r;
        hs_nxt = hs_r;
        rx_clear = 1'b0;
        rx_sample = 1'b0;
        // Clock stretch ends when the register side answers. [RL12]
        if (wait_r && reg_ready_i) begin
            wait_nxt = 1'b0;
            if (state_r == srp_pkg::S_LOAD) begin
                tx_nxt = reg_rdata_i;
                txcnt_nxt = 3'h0;
                state_nxt = srp_pkg::S_TX;
            end
        end
        case (state_r)
            srp_pkg::S_RX: begin
                if (scl_rise && !rx_full) begin
                    rx_sample = 1'b1; // [RL11]
                end else if (scl_fall && rx_full) begin
                    case (kind_r)
                        srp_pkg::K_ADDR: begin
                            if (rx_byte[7:3] == srp_pkg::MCODE_PREFIX) begin
                                hs_nxt = 1'b1; // [RL16] [RL17]
                                state_nxt = srp_pkg::S_NACK;
                            end else if (rx_byte[7:1] == TARGET_ADDR) begin
                                dir_nxt = rx_byte[srp_pkg::DIR_BIT]; // [RL3] [RL4]
                                state_nxt = srp_pkg::S_ACK; // [RL6]
                            end else begin
                                state_nxt = srp_pkg::S_IGNORE; // [RL13] [RL18]
                            end
                        end
                        srp_pkg::K_PTR: begin
                            ptr_nxt = rx_byte[6:0]; // [RL7]
                            inc_nxt = rx_byte[srp_pkg::PTR_INC_BIT]; // [RL8]
                            state_nxt = srp_pkg::S_ACK; // [RL6]
                        end
                        default: begin
                            wr_nxt = 1'b1; // [RL9]
                            wdata_nxt = rx_byte;
                            wait_nxt = 1'b1; // [RL12]
                            state_nxt = srp_pkg::S_ACK; // [RL6]
                        end
                    endcase
                end
            end
            srp_pkg::S_ACK: begin
                if (scl_fall) begin
                    rx_clear = 1'b1;
                    if (kind_r == srp_pkg::K_ADDR && dir_r) begin
                        rd_nxt = 1'b1; // [RL10]
                        wait_nxt = 1'b1;
                        state_nxt = srp_pkg::S_LOAD;
                    end else begin
                        state_nxt = srp_pkg::S_RX;
                        kind_nxt = (kind_r == srp_pkg::K_ADDR) ? srp_pkg::K_PTR : srp_pkg::K_DATA;
                        if (kind_r == srp_pkg::K_DATA && inc_r) begin
                            ptr_nxt = ptr_r + 7'h01; // [RL8]
                        end
                    end
                end
            end
            srp_pkg::S_NACK: begin
                if (scl_fall) begin
                    state_nxt = srp_pkg::S_IGNORE;
                end
            end
            srp_pkg::S_TX: begin
                if (scl_fall) begin
                    if (txcnt_r == 3'h7) begin
                        state_nxt = srp_pkg::S_MACK;
                    end else begin
                        tx_nxt = {tx_r[6:0], 1'b1}; // [RL11]
                        txcnt_nxt = txcnt_r + 3'h1;
                    end
                end
            end
            srp_pkg::S_MACK: begin
                if (scl_rise) begin
                    mack_nxt = sda_s;
                end else if (scl_fall) begin
                    if (inc_r) begin
                        ptr_nxt = ptr_r + 7'h01; // [RL8]
                    end
                    if (!mack_r) begin
                        rd_nxt = 1'b1; // [RL10]
                        wait_nxt = 1'b1;
                        state_nxt = srp_pkg::S_LOAD;
                    end else begin
                        state_nxt = srp_pkg::S_IGNORE;
                    end
                end
            end
            srp_pkg::S_IDLE, srp_pkg::S_LOAD, srp_pkg::S_IGNORE: begin
                state_nxt = state_nxt;
            end
            default: begin
                state_nxt = srp_pkg::S_IDLE;
            end
        endcase
        // A START or repeated START reopens address reception while I2C is selected. [RL2] [RL18]
        if (start_det) begin
            state_nxt = srp_pkg::S_RX;
            kind_nxt = srp_pkg::K_ADDR;
            rx_clear = 1'b1;
            busy_nxt = 1'b1;
            wait_nxt = 1'b0;
        end
        // STOP frees the bus and leaves high-speed mode. [RL14] [RL17]
        if (stop_det || !sel_s) begin
            state_nxt = srp_pkg::S_IDLE;
            busy_nxt = 1'b0;
            hs_nxt = 1'b0;
            wait_nxt = 1'b0;
        end
        // Open-drain drive: low for acknowledge and for zero data bits. [RL5] [RL1]
        sda_oe_nxt = (state_nxt == srp_pkg::S_ACK) || (state_nxt == srp_pkg::S_TX && !tx_nxt[7]);
    end

    // Register all protocol state; outputs come straight from these flops.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= srp_pkg::S_IDLE;
            kind_r <= srp_pkg::K_ADDR;
            dir_r <= 1'b0;
            ptr_r <= srp_pkg::PTR_RST;
            inc_r <= 1'b0;
            tx_r <= srp_pkg::TX_RST;
            txcnt_r <= 3'h0;
            wait_r <= 1'b0;
            mack_r <= 1'b1;
            sda_oe_r <= 1'b0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            wdata_r <= 8'h00;
            busy_r <= 1'b0;
            hs_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            dir_r <= dir_nxt;
            ptr_r <= ptr_nxt;
            inc_r <= inc_nxt;
            tx_r <= tx_nxt;
            txcnt_r <= txcnt_nxt;
            wait_r <= wait_nxt;
            mack_r <= mack_nxt;
            sda_oe_r <= sda_oe_nxt;
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            wdata_r <= wdata_nxt;
            busy_r <= busy_nxt;
            hs_r <= hs_nxt;
        end
    end

    // Both pins are open drain, so the driven level is always low.
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = wait_r;
    assign sda_oe_o = sda_oe_r;
    assign reg_addr_o = ptr_r;
    assign reg_wdata_o = wdata_r;
    assign reg_wr_o = wr_r;
    assign reg_rd_o = rd_r;
    assign busy_o = busy_r;
    assign hs_mode_o = hs_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);

    // Own address is acknowledged on the fall that ends the address byte.
    chk_addr_ack: assert property ( // [RL6]
        (state_r == srp_pkg::S_RX && kind_r == srp_pkg::K_ADDR && rx_full && scl_fall && sel_s
         && rx_byte[7:1] == TARGET_ADDR) |=> sda_oe_o ##1 sda_oe_o)
        else $error("Own address not acknowledged.");

    // A foreign address leaves SDA released until the next START.
    chk_ignore_quiet: assert property ( // [RL18]
        (state_r == srp_pkg::S_IGNORE) |-> (!sda_oe_o && !reg_wr_o && !reg_rd_o))
        else $error("Drive or access while ignoring the bus.");

    // A master code is never acknowledged and enters high-speed mode.
    chk_mcode_nack: assert property ( // [RL16]
        (state_r == srp_pkg::S_RX && kind_r == srp_pkg::K_ADDR && rx_full && scl_fall && sel_s
         && rx_byte[7:3] == srp_pkg::MCODE_PREFIX) |=> (!sda_oe_o && hs_mode_o)[*2])
        else $error("Master code acknowledged.");

    // SPI selection releases both lines and clears busy from the next cycle.
    chk_spi_quiet: assert property ( // [RL1]
        !sel_s |=> (!sda_oe_o && !scl_oe_o && !busy_o))
        else $error("I2C target active while SPI selected.");

    // START makes the bus busy; STOP frees it and ends high-speed mode.
    chk_start_busy: assert property ( // [RL2]
        (start_det && sel_s) |=> busy_o)
        else $error("START did not mark the bus busy.");
    chk_stop_free: assert property ( // [RL14] [RL17]
        stop_det |=> (!busy_o && !hs_mode_o))
        else $error("STOP did not free the bus.");

    // The pointer byte loads the register address.
    chk_ptr_load: assert property ( // [RL7]
        (state_r == srp_pkg::S_RX && kind_r == srp_pkg::K_PTR && rx_full && scl_fall && sel_s)
        |=> (reg_addr_o == $past(rx_byte[6:0])))
        else $error("Pointer byte not loaded.");

    // With increment set, each written byte advances the address by one.
    chk_auto_inc: assert property ( // [RL8]
        (state_r == srp_pkg::S_ACK && kind_r == srp_pkg::K_DATA && inc_r && scl_fall && sel_s && !stop_det)
        |=> (reg_addr_o == $past(reg_addr_o) + 7'h01))
        else $error("Register address did not advance.");

    // Acknowledge is held low for the whole acknowledge slot.
    chk_ack_stable: assert property ( // [RL5]
        (state_r == srp_pkg::S_ACK) |-> sda_oe_o)
        else $error("Acknowledge released inside its slot.");

    // The first bit sent is the MSB of the fetched byte.
    chk_msb_first: assert property ( // [RL11]
        (state_r == srp_pkg::S_LOAD && wait_r && reg_ready_i && sel_s && !start_det && !stop_det)
        |=> (sda_oe_o == !$past(reg_rdata_i[7])))
        else $error("First transmitted bit is not the MSB.");

    // A stretch is released one cycle after the register side is ready.
    chk_stretch_end: assert property ( // [RL12]
        (scl_oe_o && reg_ready_i) |=> !scl_oe_o)
        else $error("SCL stretch not released.");

endmodule

// ===== testbench/srp_ctl_model.sv
// Behavioural I2C bus controller that drives the open-drain clock and data lines.
`timescale 1ns/100ps
module srp_ctl_model #(
    parameter int T_LOW = 1350,
    parameter int T_HIGH = 650
) (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_low_o,
    output logic sda_low_o
);
    // Both lines start released, so the pull-ups hold them high.
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end

    // Releases the clock and waits, bounded, while the target stretches it low.
    task automatic release_clock();
        int n;
        n = 0;
        scl_low_o = 1'b0;
        while (scl_i !== 1'b1 && n < 4000) begin
            #25;
            n++;
        end
    endtask

    // One clock pulse: data is set only while the clock is low, sampled mid-high.
    task automatic bit_io(input logic b, output logic r);
        #300 sda_low_o = ~b;
        #(T_LOW - 300);
        release_clock();
        #(T_HIGH / 2) r = sda_i;
        #(T_HIGH / 2) scl_low_o = 1'b1;
    endtask

    // Opens a transaction; a repeated one first lifts the clock with data released.
    task automatic start_cond();
        if (scl_low_o) begin
            #300 sda_low_o = 1'b0;
            #(T_LOW - 300);
            release_clock();
            #(T_HIGH / 2);
        end
        sda_low_o = 1'b1;
        #(T_HIGH);
        scl_low_o = 1'b1;
    endtask

    // Ends the transaction with data rising while the clock is high.
    task automatic stop_cond();
        #300 sda_low_o = 1'b1;
        #(T_LOW - 300);
        release_clock();
        #(T_HIGH);
        sda_low_o = 1'b0;
        #(T_LOW);
    endtask

    // Eight bits most significant first, then the acknowledge slot.
    task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack);
    endtask
endmodule

// ===== testbench/sensor_i2c_register_port_test.sv
// Self-checking bench for the I2C register port against a controller model.
`timescale 1ns/100ps
module sensor_i2c_register_port_test;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic if_sel = 1'b1;
    logic reg_ready = 1'b1;
    logic [7:0] reg_rdata = 8'h00;
    logic scl_oe, sda_oe, ctl_scl_low, ctl_sda_low, reg_wr, reg_rd, busy, hs, ack;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, rx;
    wire scl_w, sda_w;
    int failures = 0, samples_checked = 0, cycles = 0, ready_dly = 0, rdy_cnt = 0, stretch_cyc = 0;
    logic [14:0] wlog[$];

    // Core clock with a 100 ns period.
    always #50 core_clk = ~core_clk;

    // Open-drain lines with pull-ups: low while any party pulls them.
    assign scl_w = ~(ctl_scl_low | scl_oe);
    assign sda_w = ~(ctl_sda_low | sda_oe);

    srp_i2c_port i_dut (.core_clk_i(core_clk), .nrst_i(nrst), .if_sel_i(if_sel), .scl_i(scl_w), .scl_o(),
        .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata),
        .reg_ready_i(reg_ready), .busy_o(busy), .hs_mode_o(hs));

    srp_ctl_model i_ctl (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(ctl_scl_low), .sda_low_o(ctl_sda_low));

    // Register-side user model with a settable delay, write log and hang limit.
    always @(negedge core_clk) begin
        if (reg_wr) wlog.push_back({reg_addr, reg_wdata});
        if (reg_wr || reg_rd) rdy_cnt = ready_dly;
        else if (rdy_cnt > 0) rdy_cnt--;
        reg_ready <= (rdy_cnt == 0);
        reg_rdata <= {1'b0, reg_addr} ^ 8'h5A;
        if (scl_oe) stretch_cyc++;
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("MISMATCH run_length expected below 20000 seen %0d", cycles);
            give_verdict();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Compares one observed value with its expectation.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Sends one byte and judges the target's acknowledge slot.
    task automatic send(input string what, input logic [7:0] b, input logic exp_ack);
        i_ctl.byte_io(b, 1'b1, rx, ack);
        check(what, 16'(ack), 16'(exp_ack));
    endtask

    // Idle outputs after reset.
    task automatic t_reset();
        check("busy", 16'(busy), 16'h0000);
        check("oe", 16'({scl_oe, sda_oe, hs}), 16'h0000);
        check("addr", 16'(reg_addr), 16'h0000);
    endtask

    // Two-byte write with increment while the user side stalls.
    task automatic t_write_inc();
        ready_dly = 20;
        stretch_cyc = 0;
        wlog.delete();
        i_ctl.start_cond();
        check("busy", 16'(busy), 16'h0001);
        send("addr_w", 8'hBE, 1'b0);
        send("ptr", 8'h90, 1'b0);
        send("d0", 8'h3C, 1'b0);
        send("d1", 8'hC3, 1'b0);
        i_ctl.stop_cond();
        check("busy", 16'(busy), 16'h0000);
        check("nwr", 16'(wlog.size()), 16'h0002);
        check("w0", 16'(wlog[0]), 16'({7'h10, 8'h3C}));
        check("w1", 16'(wlog[1]), 16'({7'h11, 8'hC3}));
        check("stretch", 16'(stretch_cyc >= 40), 16'h0001);
    endtask

    // Two writes with increment off land on the same register.
    task automatic t_write_fixed();
        ready_dly = 0;
        wlog.delete();
        i_ctl.start_cond();
        send("addr_w", 8'hBE, 1'b0);
        send("ptr", 8'h20, 1'b0);
        send("d0", 8'hA5, 1'b0);
        send("d1", 8'h5A, 1'b0);
        i_ctl.stop_cond();
        check("w0", 16'(wlog[0]), 16'({7'h20, 8'hA5}));
        check("w1", 16'(wlog[1]), 16'({7'h20, 8'h5A}));
    endtask

    // Pointer, repeated start, three bytes read, last one refused.
    task automatic t_read();
        ready_dly = 4;
        i_ctl.start_cond();
        send("addr_w", 8'hBE, 1'b0);
        send("ptr", 8'hA8, 1'b0);
        i_ctl.start_cond();
        send("addr_r", 8'hBF, 1'b0);
        for (int i = 0; i < 3; i++) begin
            i_ctl.byte_io(8'hFF, i == 2, rx, ack);
            check("rdata", 16'(rx), 16'({1'b0, 7'(7'h28 + i)} ^ 8'h5A));
        end
        i_ctl.stop_cond();
        check("sda_oe", 16'(sda_oe), 16'h0000);
    endtask

    // Another target's address is not answered and later bytes are ignored.
    task automatic t_foreign();
        wlog.delete();
        i_ctl.start_cond();
        send("addr_x", 8'hBC, 1'b1);
        send("ignored", 8'h00, 1'b1);
        i_ctl.stop_cond();
        check("nwr", 16'(wlog.size()), 16'h0000);
    endtask

    // Every master code is refused and high-speed mode lasts until the stop.
    task automatic t_mcode();
        for (int c = 8; c < 16; c++) begin
            i_ctl.start_cond();
            send("mcode", 8'(c), 1'b1);
            check("hs", 16'(hs), 16'h0001);
            i_ctl.start_cond();
            send("addr_hs", 8'hBE, 1'b0);
            i_ctl.stop_cond();
            check("hs", 16'(hs), 16'h0000);
        end
    endtask

    // With the select pin low the target stays silent; high brings it back.
    task automatic t_select();
        @(negedge core_clk) if_sel = 1'b0;
        repeat (4) @(negedge core_clk);
        i_ctl.start_cond();
        send("addr_off", 8'hBE, 1'b1);
        check("busy", 16'(busy), 16'h0000);
        i_ctl.stop_cond();
        @(negedge core_clk) if_sel = 1'b1;
        repeat (4) @(negedge core_clk);
        i_ctl.start_cond();
        send("addr_on", 8'hBE, 1'b0);
        i_ctl.stop_cond();
    endtask

    // Reset for four cycles, then the scenarios in turn.
    initial begin
        repeat (4) @(negedge core_clk);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
        t_reset();
        t_write_inc();
        t_write_fixed();
        t_read();
        t_foreign();
        t_mcode();
        t_select();
        give_verdict();
    end
endmodule
